/* File: rtl/mcf_defines.svh */
// register offsets, field positions, codes and timing counts of the FIFO bus master
// assumes word addressing on the control port, a 125 MHz clk_sys
`ifndef MCF_DEFINES_SVH
`define MCF_DEFINES_SVH

// -------------------------------------------------------------------------
// control port map (word index)
// -------------------------------------------------------------------------
`define MCF_A_CTRL     4'h0
`define MCF_A_CFG      4'h1
`define MCF_A_STAT     4'h2
`define MCF_A_XCNT     4'h3

`define MCF_C_GO       0
`define MCF_C_DIR      1
`define MCF_C_CH       3:2
`define MCF_C_ABORT    4
`define MCF_C_WAKE     5
`define MCF_C_RST      6

`define MCF_G_STRAP    1:0
`define MCF_G_BCD      2
`define MCF_G_WAIT     3
`define MCF_CFG_W      4
`define MCF_CFG_RST    4'h3

`define MCF_S_TMO      11

// -------------------------------------------------------------------------
// bus codes
// -------------------------------------------------------------------------
`define MCF_CH_BASE    8'h01
`define MCF_DIR_RD     4'h0
`define MCF_DIR_WR     4'h1
`define MCF_IDLE_WORD  32'hFFFF_FFFF
`define MCF_IDLE_LANES 4'hF
`define MCF_ST_OUT     4
`define MCF_PKT_SHIFT  10

// -------------------------------------------------------------------------
// timing
// -------------------------------------------------------------------------
`define MCF_CLK_NS     8
`define MCF_RST_NS     1000
`define MCF_WAKE_NS    1000
`define MCF_RST_CYC    ((`MCF_RST_NS + `MCF_CLK_NS - 1) / `MCF_CLK_NS)
`define MCF_WAKE_CYC   ((`MCF_WAKE_NS + `MCF_CLK_NS - 1) / `MCF_CLK_NS)
`define MCF_ACK_WAIT   256

`endif

/* File: rtl/mcf_pkg.sv */
// types shared by the FIFO bus master and its helpers
// assumes mcf_defines.svh holds every number but the enum encodings below
package mcf_pkg;

   typedef enum logic [4:0] {
      st_idle = 5'h01,
      st_cmd  = 5'h02,
      st_ta1  = 5'h04,
      st_data = 5'h08,
      st_ta2  = 5'h10
   } mcf_state_type;

   typedef enum logic [1:0] {
      mode_alt  = 2'h0,
      mode_one  = 2'h1,
      mode_two  = 2'h2,
      mode_four = 2'h3
   } mcf_mode_type;

endpackage : mcf_pkg

/* File: rtl/mcf_aux_if.sv */
// signals between the bus master and its two helpers
// assumes one clock domain, clk_sys
`timescale 1ns/10ps

interface mcf_aux_if;
   logic                  clear;
   logic                  take;
   logic [3:0]            lanes;
   logic                  sample;
   logic [7:0]            status_in;
   logic [7:0]            status_q;
   logic [15:0]           bytes;
   logic [5:0]            full_pkts;
   logic                  short_pkt;
   mcf_pkg::mcf_mode_type strap;
   logic                  bcd;
   logic                  rst_req;
   logic                  wake_req;
   logic [1:0]            gpio_in;
   logic                  wake_in;
   logic [1:0]            gpio_q;
   logic                  suspended;

   modport stat (input clear, take, lanes, sample, status_in,
                 output status_q, bytes, full_pkts, short_pkt);
   modport side (input strap, bcd, rst_req, wake_req, gpio_in, wake_in,
                 output gpio_q, suspended);
endinterface : mcf_aux_if

/* File: rtl/mcf_stat.sv */
// idle status capture and per-transaction byte and packet count
// assumes lanes are valid only with take
`timescale 1ns/10ps
`include "mcf_defines.svh"

module mcf_stat (
   input  wire logic clk_sys,  // system clock
   input  wire logic rstn,     // async reset, active low
   mcf_aux_if.stat   aux       // helper signals
);
   logic [15:0] bytes_q;
   logic [7:0]  stat_q;
   logic [2:0]  acc [0:4];

   assign acc[0] = 3'h0;
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign acc[i+1] = acc[i] + {2'h0, aux.lanes[i]};
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bytes_q <= 16'h0000;
         stat_q  <= 8'hFF;
      end else begin
         if (aux.clear) bytes_q <= 16'h0000;
         else if (aux.take) bytes_q <= bytes_q + {13'h0000, acc[4]};
         if (aux.sample) stat_q <= aux.status_in;
      end
   end

   // what the device will split this transaction into
   assign aux.bytes     = bytes_q;
   assign aux.full_pkts = bytes_q[15:`MCF_PKT_SHIFT];
   assign aux.short_pkt = |bytes_q[`MCF_PKT_SHIFT-1:0];
   assign aux.status_q  = stat_q;
endmodule : mcf_stat

/* File: rtl/mcf_side.sv */
// device reset pulse, mode straps, charger-detect readback and wakeup pulse
// assumes gpio and wakeup inputs are synchronous to clk_sys
`timescale 1ns/10ps
`include "mcf_defines.svh"

module mcf_side #(
   parameter int RST_CYC  = `MCF_RST_CYC,   // device reset low time
   parameter int WAKE_CYC = `MCF_WAKE_CYC   // wakeup low time
) (
   input  wire logic clk_sys,      // system clock
   input  wire logic rstn,         // async reset, active low
   mcf_aux_if.side   aux,          // helper signals
   output logic [1:0] gpio_out,    // strap values
   output logic [1:0] gpio_oe_n,   // low while straps driven
   output logic      dev_reset_n,  // device reset
   output logic      wakeup_out,   // wakeup pin level
   output logic      wakeup_oe_n   // low while pulling wakeup
);
   if (RST_CYC < 1 || RST_CYC > 255 || WAKE_CYC < 1 || WAKE_CYC > 255) begin : g_chk
      $error("mcf_side: pulse counts must lie in 1..255");
   end

   logic [7:0] rst_cnt_q;
   logic [7:0] wake_cnt_q;
   logic [1:0] gpio_q;
   logic       susp_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_cnt_q  <= 8'(RST_CYC);  // device held in reset after ours
         wake_cnt_q <= 8'h00;
         gpio_q     <= 2'h0;
         susp_q     <= 1'b0;
      end else begin
         if (aux.rst_req) rst_cnt_q <= 8'(RST_CYC);
         else if (rst_cnt_q != 8'h00) rst_cnt_q <= rst_cnt_q - 8'h01;
         if (aux.wake_req && susp_q) wake_cnt_q <= 8'(WAKE_CYC);
         else if (wake_cnt_q != 8'h00) wake_cnt_q <= wake_cnt_q - 8'h01;
         gpio_q <= aux.gpio_in;
         if (wake_cnt_q == 8'h00) susp_q <= aux.wake_in;
      end
   end

   // straps stay driven unless the device owns the pins for charger results
   assign gpio_out    = aux.strap;
   assign gpio_oe_n   = {2{aux.bcd}};
   assign dev_reset_n = (rst_cnt_q == 8'h00);
   assign wakeup_out  = 1'b0;
   assign wakeup_oe_n = (wake_cnt_q == 8'h00);
   assign aux.gpio_q    = gpio_q;
   assign aux.suspended = susp_q;
endmodule : mcf_side

/* File: rtl/mcf_host.sv */
// master of the multichannel synchronous FIFO bus, with control registers
// assumes bus pins are synchronous to clk_sys and the pad logic resolves enables
`timescale 1ns/10ps
`include "mcf_defines.svh"

// Functional notes
// - master drives idle lines high
// - master starts with request, per status
// - command phase: channel and direction code
// - direction code: zero read, one write
// - channel addresses one through four
// - word moves when request and ack low
// - read: release, device drives, turnaround
// - status sampled only after closing turnaround
// - write: only middle byte turns around
// - lane enables mark valid bytes
// - master reads whole buffer per transaction
// - idle status optional for master
module mcf_host #(
   parameter int ACK_WAIT = `MCF_ACK_WAIT   // cycles to wait for first ack
) (
   input  wire logic        clk_sys,              // system clock, 125 MHz
   input  wire logic        rstn,                 // async reset, active low
   input  wire logic [3:0]  reg_addr,             // register word index
   input  wire logic [31:0] reg_wdata,            // write data
   input  wire logic        reg_wr,               // write strobe
   input  wire logic        reg_rd,               // read strobe
   output logic [31:0]      reg_rdata,            // read data, next cycle
   input  wire logic        tx_valid,             // write word offered
   output logic             tx_ready,             // write word taken
   input  wire logic [31:0] tx_data,              // write word
   input  wire logic [3:0]  tx_lanes,             // valid bytes of word
   input  wire logic        tx_last,              // final word
   output logic             rx_valid,             // read word pulse
   output logic [31:0]      rx_data,              // read word
   output logic [3:0]       rx_lanes,             // valid bytes of read word
   input  wire logic [31:0] bus_data_in,          // data pins in
   output logic [31:0]      bus_data_out,         // data pins out
   output logic [31:0]      bus_data_oe_n,        // low while driving data
   input  wire logic [3:0]  byte_lane_enable_in,  // lane pins in
   output logic [3:0]       byte_lane_enable_out, // lane pins out
   output logic [3:0]       byte_lane_enable_oe_n,// low while driving lanes
   output logic             xact_req_n,           // transaction request
   input  wire logic        slave_ack_n,          // device acknowledge
   input  wire logic        slave_idle_status_n,  // device idle status
   input  wire logic [1:0]  gpio_in,              // strap pins in
   output logic [1:0]       gpio_out,             // strap pins out
   output logic [1:0]       gpio_oe_n,            // low while driving straps
   input  wire logic        wakeup_in,            // wakeup pin in
   output logic             wakeup_out,           // wakeup pin out
   output logic             wakeup_oe_n,          // low while pulling wakeup
   output logic             dev_reset_n           // device reset
);
   if (ACK_WAIT < 2 || ACK_WAIT > 65535) begin : g_chk
      $error("mcf_host: ACK_WAIT must lie in 2..65535");
   end

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   mcf_pkg::mcf_state_type st_q, st_d;

   logic                req_n_q, req_n_d;
   logic                dir_q;
   logic [1:0]          ch_q;
   logic                go_pend_q;
   logic                abort_q;
   logic                seen_q;
   logic                idle_ok_q;
   logic                tmo_q;
   logic [15:0]         wait_q;
   logic [3:0]          cfg_q;
   logic [31:0]         word_q, word_d;
   logic [3:0]          wlanes_q, wlanes_d;
   logic                last_q, last_d;
   logic                loaded_q, loaded_d;
   logic [31:0]         out_q, out_d;
   logic [3:0]          lout_q, lout_d;
   logic                oe_hi_n_q, oe_mid_n_q;
   logic                rx_valid_q;
   logic [31:0]         rx_data_q;
   logic [3:0]          rx_lanes_q;
   logic [31:0]         rdata_q;
   logic                wake_p_q, rst_p_q;

   mcf_aux_if aux ();

   // -------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------
   wire in_idle   = (st_q == mcf_pkg::st_idle);
   wire in_data   = (st_q == mcf_pkg::st_data);
   wire wr_ctrl   = reg_wr && (reg_addr == `MCF_A_CTRL);
   wire wr_cfg    = reg_wr && (reg_addr == `MCF_A_CFG);
   wire wr_stat   = reg_wr && (reg_addr == `MCF_A_STAT);
   wire go_w      = wr_ctrl && reg_wdata[`MCF_C_GO] && in_idle && !go_pend_q;
   wire abort_w   = wr_ctrl && reg_wdata[`MCF_C_ABORT];
   wire take_w    = in_data && !req_n_q && !slave_ack_n;
   wire take_wr   = take_w && dir_q;
   wire take_rd   = take_w && !dir_q;
   wire tmo_w     = in_data && !seen_q && (wait_q == 16'(ACK_WAIT - 1));
   wire ack_gone  = in_data && seen_q && slave_ack_n;

   // status is a hint only; the ack decides what moves
   wire [2:0] st_idx = dir_q ? {1'b0, ch_q} : 3'(`MCF_ST_OUT) + {1'b0, ch_q};
   wire chan_rdy  = !aux.status_q[st_idx];
   wire start_w   = go_pend_q && idle_ok_q && !abort_q
                    && (!cfg_q[`MCF_G_WAIT] || chan_rdy);

   // a word last in its transaction closes the write once it has moved
   wire wr_phase  = dir_q && (st_q == mcf_pkg::st_ta1 || in_data);
   assign tx_ready = wr_phase && !abort_q && !(loaded_q && last_q)
                     && (!loaded_q || take_wr);
   wire load_w    = tx_valid && tx_ready;

   // -------------------------------------------------------------------
   // holding word
   // -------------------------------------------------------------------
   always_comb begin
      word_d   = word_q;
      wlanes_d = wlanes_q;
      last_d   = last_q;
      loaded_d = loaded_q;
      if (take_wr) begin
         loaded_d = 1'b0;
      end
      if (load_w) begin
         word_d   = tx_data;
         wlanes_d = tx_lanes;
         last_d   = tx_last;
         loaded_d = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // transaction sequence
   // -------------------------------------------------------------------
   always_comb begin
      st_d    = st_q;
      req_n_d = req_n_q;
      case (st_q)
         mcf_pkg::st_idle: begin
            if (start_w) begin
               st_d    = mcf_pkg::st_cmd;
               req_n_d = 1'b0;
            end
         end
         mcf_pkg::st_cmd: begin
            st_d = mcf_pkg::st_ta1;
         end
         mcf_pkg::st_ta1: begin
            if (dir_q && !loaded_d) begin
               st_d    = mcf_pkg::st_ta2;
               req_n_d = 1'b1;
            end else begin
               st_d = mcf_pkg::st_data;
            end
         end
         mcf_pkg::st_data: begin
            // in a write, request may only sit low while a real word is on the pins
            if (abort_q || tmo_w || ack_gone || (dir_q && !loaded_d)) begin
               st_d    = mcf_pkg::st_ta2;
               req_n_d = 1'b1;
            end
         end
         mcf_pkg::st_ta2: begin
            st_d = mcf_pkg::st_idle;
         end
         default: begin
            st_d    = mcf_pkg::st_idle;
            req_n_d = 1'b1;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // pin values for the coming cycle
   // -------------------------------------------------------------------
   wire nx_cmd   = (st_d == mcf_pkg::st_cmd);
   wire nx_wdata = dir_q && (st_d == mcf_pkg::st_ta1 || st_d == mcf_pkg::st_data);
   wire nx_rbus  = !dir_q && (st_d == mcf_pkg::st_ta1 || st_d == mcf_pkg::st_data
                              || st_d == mcf_pkg::st_ta2);

   always_comb begin
      out_d  = `MCF_IDLE_WORD;
      lout_d = `MCF_IDLE_LANES;
      if (nx_cmd) begin
         out_d[7:0] = `MCF_CH_BASE + {6'h00, ch_q};
         lout_d     = dir_q ? `MCF_DIR_WR : `MCF_DIR_RD;
      end else if (nx_wdata) begin
         out_d  = word_d;
         lout_d = wlanes_d;
      end
   end

   // -------------------------------------------------------------------
   // registers of the sequence
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q       <= mcf_pkg::st_idle;
         req_n_q    <= 1'b1;
         out_q      <= `MCF_IDLE_WORD;
         lout_q     <= `MCF_IDLE_LANES;
         oe_hi_n_q  <= 1'b0;
         oe_mid_n_q <= 1'b1;
         idle_ok_q  <= 1'b0;
      end else begin
         st_q       <= st_d;
         req_n_q    <= req_n_d;
         out_q      <= out_d;
         lout_q     <= lout_d;
         oe_hi_n_q  <= nx_rbus;
         oe_mid_n_q <= !(nx_wdata && st_d == mcf_pkg::st_data);
         idle_ok_q  <= (st_d == mcf_pkg::st_idle) && in_idle;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         word_q   <= 32'h0000_0000;
         wlanes_q <= 4'h0;
         last_q   <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         word_q   <= word_d;
         wlanes_q <= wlanes_d;
         last_q   <= last_d;
         loaded_q <= loaded_d;
      end
   end

   // an untaken word survives a full buffer and leads the next write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         seen_q <= 1'b0;
         wait_q <= 16'h0000;
      end else if (!in_data) begin
         seen_q <= 1'b0;
         wait_q <= 16'h0000;
      end else begin
         if (!slave_ack_n) seen_q <= 1'b1;
         if (!seen_q) wait_q <= wait_q + 16'h0001;
      end
   end

   // -------------------------------------------------------------------
   // read words
   // -------------------------------------------------------------------
   // no length cap: a read runs until the device stops acking
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_valid_q <= 1'b0;
         rx_data_q  <= 32'h0000_0000;
         rx_lanes_q <= 4'h0;
      end else begin
         rx_valid_q <= take_rd;
         if (take_rd) begin
            rx_data_q  <= bus_data_in;
            rx_lanes_q <= byte_lane_enable_in;
         end
      end
   end

   // -------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         go_pend_q <= 1'b0;
         dir_q     <= 1'b0;
         ch_q      <= 2'h0;
         abort_q   <= 1'b0;
         cfg_q     <= `MCF_CFG_RST;
         tmo_q     <= 1'b0;
         wake_p_q  <= 1'b0;
         rst_p_q   <= 1'b0;
      end else begin
         if (go_w) begin
            go_pend_q <= 1'b1;
            dir_q     <= reg_wdata[`MCF_C_DIR];
            ch_q      <= reg_wdata[`MCF_C_CH];
         end else if (start_w || abort_w) begin
            go_pend_q <= 1'b0;
         end
         if (abort_w && !in_idle) abort_q <= 1'b1;
         else if (in_idle) abort_q <= 1'b0;
         if (wr_cfg) cfg_q <= reg_wdata[`MCF_CFG_W-1:0];
         // a timeout in the clearing cycle stays visible
         if (tmo_w) tmo_q <= 1'b1;
         else if (wr_stat && reg_wdata[`MCF_S_TMO]) tmo_q <= 1'b0;
         wake_p_q <= wr_ctrl && reg_wdata[`MCF_C_WAKE];
         rst_p_q  <= wr_ctrl && reg_wdata[`MCF_C_RST];
      end
   end

   // -------------------------------------------------------------------
   // read-back
   // -------------------------------------------------------------------
   wire [31:0] r_ctrl = {23'h000000, st_q, loaded_q, go_pend_q, !in_idle, abort_q};
   wire [31:0] r_cfg  = {28'h0000000, cfg_q};
   wire [31:0] r_stat = {20'h00000, tmo_q, aux.suspended, aux.gpio_q, aux.status_q};
   wire [31:0] r_xcnt = {9'h000, aux.short_pkt, aux.full_pkts, aux.bytes};
   wire [31:0] r_mux  = (reg_addr == `MCF_A_CTRL) ? r_ctrl :
                        (reg_addr == `MCF_A_CFG)  ? r_cfg  :
                        (reg_addr == `MCF_A_STAT) ? r_stat :
                        (reg_addr == `MCF_A_XCNT) ? r_xcnt : 32'h0000_0000;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rdata_q <= 32'h0000_0000;
      else rdata_q <= reg_rd ? r_mux : 32'h0000_0000;
   end

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   assign aux.clear     = start_w;
   assign aux.take      = take_w;
   assign aux.lanes     = dir_q ? wlanes_q : byte_lane_enable_in;
   assign aux.sample    = idle_ok_q;
   assign aux.status_in = bus_data_in[15:8];
   assign aux.strap     = mcf_pkg::mcf_mode_type'(cfg_q[`MCF_G_STRAP]);
   assign aux.bcd       = cfg_q[`MCF_G_BCD];
   assign aux.rst_req   = rst_p_q;
   assign aux.wake_req  = wake_p_q;
   assign aux.gpio_in   = gpio_in;
   assign aux.wake_in   = wakeup_in;

   mcf_stat u_stat (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .aux     (aux)
   );

   mcf_side u_side (
      .clk_sys     (clk_sys),
      .rstn        (rstn),
      .aux         (aux),
      .gpio_out    (gpio_out),
      .gpio_oe_n   (gpio_oe_n),
      .dev_reset_n (dev_reset_n),
      .wakeup_out  (wakeup_out),
      .wakeup_oe_n (wakeup_oe_n)
   );

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign xact_req_n            = req_n_q;
   assign bus_data_out          = out_q;
   assign bus_data_oe_n         = {{16{oe_hi_n_q}}, {8{oe_mid_n_q}}, {8{oe_hi_n_q}}};
   assign byte_lane_enable_out  = lout_q;
   assign byte_lane_enable_oe_n = {4{oe_hi_n_q}};
   assign rx_valid              = rx_valid_q;
   assign rx_data               = rx_data_q;
   assign rx_lanes              = rx_lanes_q;
   assign reg_rdata             = rdata_q;
endmodule : mcf_host

/* File: verif/mcf_props.sv */
// fifo bus pin checks for mcf_host, bound from tb
`timescale 1ns/10ps
module mcf_props (
   input wire logic        clk_sys, rstn, xact_req_n, slave_ack_n, rx_valid,
   input wire logic [31:0] bus_data_out, bus_data_oe_n, bus_data_in, rx_data,
   input wire logic [3:0]  byte_lane_enable_out, byte_lane_enable_oe_n, byte_lane_enable_in,
   input wire logic [3:0]  rx_lanes
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence cmd_s;
      $fell(xact_req_n);
   endsequence
   idle_drive_a: assert property (xact_req_n && $past(xact_req_n) |-> byte_lane_enable_out == 4'hF
      && {bus_data_out[31:16], bus_data_out[7:0]} == 24'hFFFFFF) else $error("idle lines low");
   mid_free_a: assert property (xact_req_n |-> &bus_data_oe_n[15:8]) else $error("mid byte driven");
   cmd_code_a: assert property (cmd_s |-> byte_lane_enable_out inside {4'h0, 4'h1}
      && bus_data_out[7:0] inside {[8'h01:8'h04]} && !(|byte_lane_enable_oe_n)) else $error("bad cmd");
   rd_turn_a: assert property (cmd_s ##0 byte_lane_enable_out == 4'h0 |=>
      &bus_data_oe_n && &byte_lane_enable_oe_n) else $error("read ta1 driven");
   wr_turn_a: assert property (cmd_s ##0 byte_lane_enable_out == 4'h1 |->
      (!(|byte_lane_enable_oe_n) && &bus_data_oe_n[15:8])[*2]) else $error("write ta wrong");
   rx_take_a: assert property (rx_valid |-> !$past(xact_req_n) && !$past(slave_ack_n)
      && rx_data == $past(bus_data_in) && rx_lanes == $past(byte_lane_enable_in)) else $error("rx");
   ack_end_a: assert property (!xact_req_n && slave_ack_n && !$past(slave_ack_n) |=>
      xact_req_n) else $error("no end on ack");
   gap_idle_a: assert property ($rose(xact_req_n) |-> xact_req_n[*3]) else $error("gap short");
endmodule : mcf_props

/* File: verif/mcf_slave_model.sv */
// far-side bus slave: idle status, acks, read words, limited write room
`timescale 1ns/10ps
module mcf_slave_model (
   input  wire logic        clk_sys, rstn, req_n, // clock, reset, request
   input  wire logic [3:0]  lin,                  // lanes seen
   input  wire logic [31:0] din,                  // data seen
   input  wire logic [7:0]  stat,                 // active-low status
   input  wire logic [15:0] rd_n, room,           // buffer fill and room
   output logic             ack_n, drv, st,       // ack, data drive, status drive
   output logic [3:0]       lout,                 // read lanes
   output logic [31:0]      dout, got             // driven word, last written word
);
   logic [1:0]  ph;
   logic        rd;
   logic [15:0] k;
   assign drv  = ph == 2'h2 && rd && !ack_n;
   assign st   = ph == 2'h0 && req_n;
   assign dout = st ? {16'h0, stat, 8'h0} : 32'hA5000000 + {16'h0, k};
   assign lout = k + 16'h1 == rd_n ? 4'h3 : 4'hF;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ph <= 2'h0; ack_n <= 1'b1; k <= 16'h0; got <= 32'h0; rd <= 1'b0;
      end else if (req_n) begin
         ph <= 2'h0; ack_n <= 1'b1; k <= 16'h0;
      end else if (ph == 2'h0) begin
         ph <= 2'h1; rd <= lin == 4'h0;
      end else if (ph == 2'h1) begin
         ph <= 2'h2; ack_n <= (rd ? rd_n : room) == 16'h0;
      end else if (!ack_n) begin
         k <= k + 16'h1;
         if (!rd) got <= din;
         ack_n <= k + 16'h1 == (rd ? rd_n : room);
      end
   end
endmodule : mcf_slave_model

/* File: verif/tb.sv */
// bench for mcf_host against the slave model; control port tasks drive it
`timescale 1ns/10ps
module tb;
   logic        clk_sys, rstn, reg_wr, reg_rd, rx_valid, req_n, tx_ready, ack_n, drv, st, woe;
   logic [3:0]  reg_addr, lo, loe, lout, ll, lastl;
   logic [31:0] reg_wdata, reg_rdata, rx_data, bdo, boe, dout, got, v;
   logic [3:0]  rx_lanes;
   logic [15:0] idx, n, rd_n, room;
   logic [1:0]  gpo, goe;
   logic [7:0]  stat;
   int          errors, comparisons;
   logic [31:0] q[$];
   wire  [31:0] sm = {32{drv}} | {16'h0, {8{st}}, 8'h0};
   // released lines the model does not drive show the inverse of the last host value
   wire  [31:0] bin = ~boe & bdo | boe & sm & dout | boe & ~sm & ~bdo;
   wire  [3:0]  lin = ~loe & lo | loe & (drv ? lout : ~lo);
   mcf_host mcf_host_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .tx_valid(idx < n), .tx_ready, .tx_data(32'hC0DE0000 + {16'h0, idx}),
      .tx_lanes(idx == n - 16'h1 ? ll : 4'hF), .tx_last(idx == n - 16'h1), .rx_valid, .rx_data,
      .rx_lanes, .bus_data_in(bin), .bus_data_out(bdo), .bus_data_oe_n(boe),
      .byte_lane_enable_in(lin), .byte_lane_enable_out(lo), .byte_lane_enable_oe_n(loe),
      .xact_req_n(req_n), .slave_ack_n(ack_n), .slave_idle_status_n(!st), .gpio_in(2'h2),
      .gpio_out(gpo), .gpio_oe_n(goe), .wakeup_in(1'b1), .wakeup_out(), .wakeup_oe_n(woe),
      .dev_reset_n());
   mcf_slave_model mcf_slave_model_inst (.clk_sys, .rstn, .req_n, .lin, .din(bin), .stat, .rd_n,
      .room, .ack_n, .drv, .st, .lout, .dout, .got);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) begin
         q.push_back(rx_data);
         lastl <= rx_lanes;
      end
      if (idx < n && tx_ready === 1'b1) idx <= idx + 16'h1;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic xfer(input logic [3:0] c); // c = {channel, dir, go}
      wr(4'h0, {28'h0, c});
      repeat (400) begin
         rd(4'h0);
         if (v[2:1] === 2'h0) return;
      end
      errors++;
      print_verdict();
   endtask : xfer
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, idx, n, lastl} = '0;
      {ll, rd_n, room, stat} = {4'hF, 16'h3, 16'hFFFF, 8'hEE};
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(4'h1); chk(v, 32'h3);
      chk({30'h0, gpo}, 32'h3);
      for (int c = 0; c < 4; c++) begin
         q = {};
         xfer({c[1:0], 2'h1});
         chk(32'(q.size()), 32'h3);
         for (int i = 0; i < 3; i++) chk(q[i], 32'hA5000000 + i);
         chk({28'h0, lastl}, 32'h3);
      end
      {idx, n, ll} <= {16'h0, 16'd257, 4'h1};
      xfer(4'h3);
      chk(got, 32'hC0DE0100);
      rd(4'h3); chk(v, 32'h0041_0401);
      {idx, n, ll, room} <= {16'h0, 16'h3, 4'hF, 16'h2};
      xfer(4'hF);
      chk(got, 32'hC0DE0001);
      rd(4'h3); chk({16'h0, v[15:0]}, 32'h8);
      rd(4'h2); chk({22'h0, v[9:0]}, 32'h2EE);
      wr(4'h0, 32'h20); rd(4'h2); chk({30'h0, v[10], woe}, 32'h2);
      wr(4'h1, 32'h7); rd(4'hF); chk(v, 32'h0);
      chk({30'h0, goe}, 32'h3);
      print_verdict();
   end
endmodule : tb
bind mcf_host mcf_props mcf_props_inst (.*);
